// >>> src/mpt_timer_cfg.svh
// Purpose: register map, field positions and reset values of the timer
// Assumes: byte addresses on an 8-bit register port, 32-bit data
// Notes: channel n registers sit at region base + 4*n (addr[4:2] = n)
`ifndef MPT_TIMER_CFG_SVH
`define MPT_TIMER_CFG_SVH
`define MPT_A_CTRL 8'h00
`define MPT_A_MOD  8'h04
`define MPT_A_STAT 8'h08
`define MPT_A_CNT  8'h0C
`define MPT_A_PINS 8'h10
`define MPT_A_POL  8'h14
`define MPT_A_DT   8'h18
`define MPT_A_TRIG 8'h1C
`define MPT_A_DITH 8'h20
`define MPT_A_QPOS 8'h24
`define MPT_A_QCMP 8'h28
`define MPT_A_QCAP 8'h2C
`define MPT_A_CHFL 8'h30
`define MPT_R_CFG  3'h2
`define MPT_R_CV   3'h3
`define MPT_R_CV2  3'h4
`define MPT_F_SRC  1:0
`define MPT_F_PS   4:2
`define MPT_F_SGN  5
`define MPT_F_HALF 6
`define MPT_F_FULL 7
`define MPT_F_DITH 8
`define MPT_F_EN   9
`define MPT_CTRL_RST 10'h080
`define MPT_MOD_RST  16'hFFFF
`define MPT_S_TOF  0
`define MPT_S_FLT  1
`define MPT_S_RLD  2
`define MPT_S_POS  3
`endif

// >>> src/mpt_pkg.sv
// Purpose: types shared by the capture/compare timer
// Assumes: nothing beyond the cfg header
// Notes: codes are the values software writes
package mpt_pkg;
  typedef enum logic [1:0] {
    MD_OFF = 2'b00, MD_CAP = 2'b01, MD_CMP = 2'b10, MD_PWM = 2'b11
  } mpt_mode_e;
  typedef enum logic [1:0] {
    SRC_SYS = 2'b00, SRC_FIX = 2'b01, SRC_EXT = 2'b10, SRC_OFF = 2'b11
  } mpt_src_e;
endpackage : mpt_pkg

// >>> src/mpt_timer.sv
// Purpose: multi-channel 16-bit capture/compare/PWM timer
// Assumes: single clock, pins are asynchronous and synchronised here
// Notes: motor instance HASFLT=1, quadrature instance HASQD=1
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "mpt_timer_cfg.svh"
module mpt_timer import mpt_pkg::*; #(
  parameter int NCH    = 6,
  parameter int NFLT   = 4,
  parameter bit HASFLT = 1'b1,
  parameter bit HASQD  = 1'b0
) (
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic [7:0]      regAddr,
  input  wire logic [31:0]     regWdata,
  input  wire logic            regWr,
  input  wire logic            regRd,
  output var  logic [31:0]     regRdata,
  input  wire logic            fixedTick,
  input  wire logic            extClkPin,
  input  wire logic [NCH-1:0]  chInPin,
  input  wire logic [NFLT-1:0] faultPin,
  input  wire logic            quadAPin,
  input  wire logic            quadBPin,
  input  wire logic            quadEvtPin,
  output var  logic [NCH-1:0]  chOut,
  output var  logic [NCH-1:0]  chOutEn,
  output var  logic            irq,
  output var  logic            initTrigOut,
  output var  logic            extTrigOut,
  output var  logic            adcTrigOut,
  output var  logic            chOrTrigOut
);
  localparam int NS = NCH + NFLT + 4;
  localparam int QA = NCH + NFLT + 1;
  logic [NS-1:0] s1_q, s2_q, s3_q;
  logic [9:0]  ctrl_q, ctrl_d;
  logic [15:0] modSh_q, modSh_d, modAct_q, modAct_d, cnt_q, cnt_d;
  logic [6:0]  ps_q, ps_d;
  logic [3:0]  stat_q, stat_d, pAcc_q, pAcc_d, dAcc_q, dAcc_d;
  logic [NCH-1:0]  pol_q, pol_d, chFl_q, chFl_d, chEv, out_q, oen_q;
  logic [NFLT-1:0] fen_q, fen_d;
  logic [7:0]  dt_q, dt_d, dith_q, dith_d;
  logic [15:0] trig_q, trig_d, qpos_q, qpos_d, qcmp_q, qcmp_d;
  logic [15:0] qcap_q, qcap_d;
  logic        pCar_q, pCar_d, dCar_q, dCar_d;
  logic [31:0] rdat_q, rdat_d;
  logic        irq_q, irq_d, iTr_q, iTr_d, eTr_q, eTr_d;
  logic        aTr_q, aTr_d, oTr_q, oTr_d;
  logic [2:0]  cfg_q [NCH];
  logic [15:0] sh_q [NCH];
  logic [15:0] act_q [NCH];
  logic [15:0] c1_q [NCH];
  logic [15:0] c2_q [NCH];
  logic [7:0]  dtc_q [NCH];
  logic [NCH-1:0] raw_q, ef_q;
  logic        srcTick, tick, fullPt, halfPt, ldPt, sgn, fltIn, qChg;
  logic [6:0]  psMask;
  logic [15:0] modEff, cntInit;
  logic [2:0]  idx;

  // two flops per pin; s3 only serves edge detection on s2
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {quadEvtPin, quadBPin, quadAPin, extClkPin, faultPin, chInPin};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // time base: source select, prescale, reload points
  always_comb begin
    case (mpt_src_e'(ctrl_q[`MPT_F_SRC]))
      SRC_SYS: srcTick = 1'b1;
      SRC_FIX: srcTick = fixedTick;
      SRC_EXT: srcTick = s2_q[NCH+NFLT] & ~s3_q[NCH+NFLT];
      default: srcTick = 1'b0;
    endcase
  end
  assign sgn     = ctrl_q[`MPT_F_SGN];
  assign psMask  = ~(7'h7F << ctrl_q[`MPT_F_PS]);
  assign tick    = ctrl_q[`MPT_F_EN] & srcTick
                 & ((ps_q & psMask) == psMask);
  assign modEff  = modAct_q + {15'h0, pCar_q};
  assign cntInit = sgn ? 16'(~modAct_q + 16'h1) : 16'h0;
  assign fullPt  = tick & (cnt_q == modEff);
  assign halfPt  = tick & (sgn ? cnt_q == 16'h0
                              : cnt_q == {1'b0, modAct_q[15:1]});
  assign ldPt    = (fullPt & ctrl_q[`MPT_F_FULL])
                 | (halfPt & ctrl_q[`MPT_F_HALF]);
  assign fltIn   = HASFLT & |(s2_q[NCH+NFLT-1:NCH] & fen_q);
  assign qChg    = HASQD & ((s2_q[QA] ^ s3_q[QA])
                 ^ (s2_q[QA+1] ^ s3_q[QA+1]));
  assign idx     = regAddr[4:2];

  // register file, counter, flags, quadrature and triggers
  always_comb begin
    ctrl_d = ctrl_q;   modSh_d = modSh_q; modAct_d = modAct_q;
    cnt_d  = cnt_q;    ps_d = ps_q;       pol_d = pol_q;
    fen_d  = fen_q;    dt_d = dt_q;       dith_d = dith_q;
    trig_d = trig_q;   qpos_d = qpos_q;   qcmp_d = qcmp_q;
    qcap_d = qcap_q;   pAcc_d = pAcc_q;   dAcc_d = dAcc_q;
    pCar_d = pCar_q;   dCar_d = dCar_q;   rdat_d = 32'h0;
    stat_d = stat_q;   chFl_d = chFl_q;
    if (srcTick)
      ps_d = ps_q + 7'h1;
    if (tick)
      cnt_d = fullPt ? cntInit : cnt_q + 16'h1;
    if (ldPt)
      modAct_d = modSh_q;
    if (fullPt) begin
      {pCar_d, pAcc_d} = ctrl_q[`MPT_F_DITH]
                       ? 5'(pAcc_q + dith_q[3:0]) : 5'h0;
      {dCar_d, dAcc_d} = ctrl_q[`MPT_F_DITH]
                       ? 5'(dAcc_q + dith_q[7:4]) : 5'h0;
    end
    if (HASQD && qChg)
      qpos_d = (s2_q[QA] ^ s3_q[QA+1]) ? qpos_q + 16'h1 : qpos_q - 16'h1;
    if (HASQD && s2_q[QA+2] && !s3_q[QA+2])
      qcap_d = qpos_q;
    // software clear first, so a same-cycle event still sets
    if (regWr && regAddr == `MPT_A_STAT)
      stat_d = stat_q & ~regWdata[3:0];
    if (regWr && regAddr == `MPT_A_CHFL)
      chFl_d = chFl_q & ~regWdata[NCH-1:0];
    if (regWr) begin
      case (regAddr)
        `MPT_A_CTRL: ctrl_d = regWdata[9:0];
        `MPT_A_MOD:  modSh_d = regWdata[15:0];
        `MPT_A_CNT:  cnt_d = cntInit;
        `MPT_A_POL:  pol_d = regWdata[NCH-1:0];
        `MPT_A_DT: begin
          dt_d  = HASFLT ? regWdata[7:0] : 8'h0;
          fen_d = regWdata[8+NFLT-1:8];
        end
        `MPT_A_TRIG: trig_d = regWdata[15:0];
        `MPT_A_DITH: dith_d = regWdata[7:0];
        `MPT_A_QPOS: qpos_d = regWdata[15:0];
        `MPT_A_QCMP: qcmp_d = regWdata[15:0];
        default: ;
      endcase
    end
    stat_d[`MPT_S_TOF] = stat_d[`MPT_S_TOF] | fullPt;
    stat_d[`MPT_S_FLT] = stat_d[`MPT_S_FLT] | fltIn;
    stat_d[`MPT_S_RLD] = stat_d[`MPT_S_RLD] | ldPt;
    stat_d[`MPT_S_POS] = stat_d[`MPT_S_POS]
                       | (qChg && qpos_d == qcmp_q);
    chFl_d = chFl_d | chEv;
    if (regRd) begin
      case (regAddr)
        `MPT_A_CTRL: rdat_d = 32'(ctrl_q);
        `MPT_A_MOD:  rdat_d = 32'(modSh_q);
        `MPT_A_STAT: rdat_d = 32'(stat_q);
        `MPT_A_CNT:  rdat_d = 32'(cnt_q);
        `MPT_A_PINS: rdat_d = 32'(s2_q[NCH-1:0]);
        `MPT_A_POL:  rdat_d = 32'(pol_q);
        `MPT_A_DT:   rdat_d = 32'({fen_q, dt_q});
        `MPT_A_TRIG: rdat_d = 32'(trig_q);
        `MPT_A_DITH: rdat_d = 32'(dith_q);
        `MPT_A_QPOS: rdat_d = 32'(qpos_q);
        `MPT_A_QCMP: rdat_d = 32'(qcmp_q);
        `MPT_A_QCAP: rdat_d = 32'(qcap_q);
        `MPT_A_CHFL: rdat_d = 32'(chFl_q);
        default:
          if (32'(idx) < NCH) begin
            case (regAddr[7:5])
              `MPT_R_CFG: rdat_d = 32'(cfg_q[idx]);
              `MPT_R_CV:  rdat_d = 32'(cfg_q[idx][1:0] == MD_CAP
                                       ? c1_q[idx] : sh_q[idx]);
              `MPT_R_CV2: rdat_d = 32'(c2_q[idx]);
              default:    rdat_d = 32'h0;
            endcase
          end
      endcase
    end
    irq_d = |stat_d;
    iTr_d = fullPt;
    eTr_d = tick & (cnt_q == trig_q);
    aTr_d = iTr_d | eTr_d;
    oTr_d = |out_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= `MPT_CTRL_RST; modSh_q <= `MPT_MOD_RST;
      modAct_q <= `MPT_MOD_RST; cnt_q <= 16'h0; ps_q <= 7'h0;
      stat_q <= 4'h0; pol_q <= '0; chFl_q <= '0; fen_q <= '0;
      dt_q <= 8'h0; dith_q <= 8'h0; trig_q <= 16'h0;
      qpos_q <= 16'h0; qcmp_q <= 16'h0; qcap_q <= 16'h0;
      pAcc_q <= 4'h0; dAcc_q <= 4'h0; pCar_q <= 1'b0; dCar_q <= 1'b0;
      rdat_q <= 32'h0; irq_q <= 1'b0; iTr_q <= 1'b0; eTr_q <= 1'b0;
      aTr_q <= 1'b0; oTr_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d; modSh_q <= modSh_d; modAct_q <= modAct_d;
      cnt_q <= cnt_d; ps_q <= ps_d; stat_q <= stat_d; pol_q <= pol_d;
      chFl_q <= chFl_d; fen_q <= fen_d; dt_q <= dt_d; dith_q <= dith_d;
      trig_q <= trig_d; qpos_q <= qpos_d; qcmp_q <= qcmp_d;
      qcap_q <= qcap_d; pAcc_q <= pAcc_d; dAcc_q <= dAcc_d;
      pCar_q <= pCar_d; dCar_q <= dCar_d; rdat_q <= rdat_d;
      irq_q <= irq_d; iTr_q <= iTr_d; eTr_q <= eTr_d;
      aTr_q <= aTr_d; oTr_q <= oTr_d;
    end
  end

  // one slice per channel: mode logic, dead time, polarity, fault
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [2:0]  cfg_d;
    logic [15:0] sh_d, act_d, c1_d, c2_d, duty;
    logic [7:0]  dtc_d;
    logic        raw_d, rawEff, rise, ev, cmp, drv, o_d, oe_d, wsel;
    if (i % 2 == 1) begin : g_odd
      // odd channel inverts its even partner when dead time is on and the partner is in PWM mode
      assign rawEff = (dt_q != 8'h0 && cfg_q[i-1][1:0] == MD_PWM)
                    ? ~raw_q[i-1] : raw_q[i];
    end else begin : g_even
      assign rawEff = raw_q[i];
    end
    assign wsel = regWr && 32'(idx) == i;
    assign duty = act_q[i] + {15'h0, dCar_q};
    assign cmp  = sgn ? $signed(cnt_q) < $signed(duty) : cnt_q < duty;
    always_comb begin
      cfg_d = cfg_q[i]; sh_d = sh_q[i]; act_d = act_q[i];
      c1_d = c1_q[i]; c2_d = c2_q[i]; raw_d = raw_q[i]; ev = 1'b0;
      rise = s2_q[i] & ~s3_q[i];
      if (wsel && regAddr[7:5] == `MPT_R_CFG)
        cfg_d = regWdata[2:0];
      if (wsel && regAddr[7:5] == `MPT_R_CV)
        sh_d = regWdata[15:0];
      if (ldPt)
        act_d = sh_q[i];
      case (mpt_mode_e'(cfg_q[i][1:0]))
        MD_CAP: begin
          if (rise) begin
            c1_d = cnt_q;
            ev = 1'b1;
          end
          if (cfg_q[i][2] && !s2_q[i] && s3_q[i]) begin
            c2_d = cnt_q;
            ev = 1'b1;
          end
        end
        MD_CMP: if (tick && cnt_q == act_q[i]) begin
          raw_d = ~raw_q[i];
          ev = 1'b1;
        end
        MD_PWM: raw_d = cmp;
        default: raw_d = 1'b0;
      endcase
      // rising edge of each output is held off for dt cycles
      // load dt-1: the rising cycle itself is already one of the dt
      dtc_d = (rawEff && !ef_q[i] && dt_q != 8'h0) ? dt_q - 8'h1
            : (dtc_q[i] != 8'h0 ? dtc_q[i] - 8'h1 : 8'h0);
      drv = rawEff && dtc_q[i] == 8'h0 && !(!ef_q[i] && dt_q != 8'h0);
      o_d = (stat_q[`MPT_S_FLT] ? 1'b0 : drv) ^ pol_q[i];
      oe_d = cfg_q[i][1];
    end
    assign chEv[i] = ev;
    always_ff @(posedge clk) begin
      if (srst) begin
        cfg_q[i] <= 3'h0; sh_q[i] <= 16'h0; act_q[i] <= 16'h0;
        c1_q[i] <= 16'h0; c2_q[i] <= 16'h0; dtc_q[i] <= 8'h0;
        raw_q[i] <= 1'b0; ef_q[i] <= 1'b0; out_q[i] <= 1'b0;
        oen_q[i] <= 1'b0;
      end else begin
        cfg_q[i] <= cfg_d; sh_q[i] <= sh_d; act_q[i] <= act_d;
        c1_q[i] <= c1_d; c2_q[i] <= c2_d; dtc_q[i] <= dtc_d;
        raw_q[i] <= raw_d; ef_q[i] <= rawEff; out_q[i] <= o_d;
        oen_q[i] <= oe_d;
      end
    end
  end

  assign regRdata    = rdat_q;
  assign chOut       = out_q;
  assign chOutEn     = oen_q;
  assign irq         = irq_q;
  assign initTrigOut = iTr_q;
  assign extTrigOut  = eTr_q;
  assign adcTrigOut  = aTr_q;
  assign chOrTrigOut = oTr_q;

  // checks on the time base, flags, outputs and register reads
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  cnt_wrap_a: assert property (fullPt |=> cnt_q == $past(cntInit))
    else $error("counter did not restart at full point");
  ps_div2_a: assert property (
    (ctrl_q[`MPT_F_PS] == 3'h1 && ctrl_q[`MPT_F_SRC] == SRC_SYS
     && tick) ##1 $stable(ctrl_q)
    |-> !tick ##1 (tick || !$stable(ctrl_q)))
    else $error("divide-by-2 prescale broken");
  mod_buffer_a: assert property (
    !ldPt |=> modAct_q == $past(modAct_q))
    else $error("modulo changed outside reload point");
  fault_set_a: assert property (fltIn |=> stat_q[`MPT_S_FLT])
    else $error("fault input did not set fault flag");
  fault_safe_a: assert property (
    stat_q[`MPT_S_FLT] |=> chOut == $past(pol_q))
    else $error("outputs not safe during fault");
  ovf_flag_a: assert property (fullPt |=> stat_q[`MPT_S_TOF] && irq)
    else $error("overflow flag or interrupt missing");
  match_trig_a: assert property (
    tick && cnt_q == trig_q |=> extTrigOut ##0 adcTrigOut)
    else $error("match trigger missing");
  pin_read_a: assert property (
    regRd && regAddr == `MPT_A_PINS
    |=> regRdata == 32'($past(s2_q[NCH-1:0])))
    else $error("pin state read wrong");
  cov_wrap_c: cover property (fullPt ##[1:1000] fullPt);
  cov_fault_c: cover property (fltIn ##1 stat_q[`MPT_S_FLT]);
  cov_cap_c: cover property (|chEv);
endmodule : mpt_timer
`default_nettype wire

// >>> verif/mpt_pins_model.sv
// Purpose: pin-side model of the bridge, fault lines and input sources
// Assumes: the bench sets chIn, fault and extRun by reference
// Notes: the external clock stands still until extRun is set
`timescale 1ns/1ps
`default_nettype none
module mpt_pins_model (
  input  wire logic       clk,
  output var  logic [5:0] chIn,
  output var  logic [3:0] fault,
  output var  logic       extClk
);
  logic extRun;

  // lines idle low so no fault or capture edge is seen at start
  initial begin
    chIn = '0;
    fault = '0;
    extClk = 1'b0;
    extRun = 1'b0;
  end

  // half-rate clock, slow enough to pass the two-stage synchroniser
  always @(posedge clk) begin
    if (extRun)
      extClk <= ~extClk;
  end
endmodule : mpt_pins_model
`default_nettype wire

// >>> verif/tb_mpt_timer.sv
// Purpose: self-checking bench of the motor capture/compare timer
// Assumes: motor instance, six channels, four fault lines
// Notes: the first wrap waits out the reset modulo of 16'hFFFF
`timescale 1ns/1ps
`default_nettype none
`include "mpt_timer_cfg.svh"
module tb_mpt_timer import mpt_pkg::*;;
  logic        clk, srst, regWr, regRd, fixedTick;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, rdv;
  logic [5:0]  chInPin, chOut, chOutEn;
  logic [3:0]  faultPin;
  logic        extClkPin, irq, initTrigOut, extTrigOut;
  logic        adcTrigOut, chOrTrigOut;
  int          miscompares, comparisons, cyc, n, cv, w, c0, po;

  mpt_timer mpt_timer_i (.clk(clk), .srst(srst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .fixedTick(fixedTick), .extClkPin(extClkPin),
    .chInPin(chInPin), .faultPin(faultPin), .quadAPin(1'b0),
    .quadBPin(1'b0), .quadEvtPin(1'b0), .chOut(chOut), .chOutEn(chOutEn),
    .irq(irq), .initTrigOut(initTrigOut), .extTrigOut(extTrigOut),
    .adcTrigOut(adcTrigOut), .chOrTrigOut(chOrTrigOut));

  mpt_pins_model mpt_pins_model_i (.clk(clk), .chIn(chInPin),
    .fault(faultPin), .extClk(extClkPin));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // hang guard, well above the longest wait of the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe, so look mid-cycle
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    rdv = regRdata;
  endtask : rd

  // cycles up to and including the next wrap pulse
  task automatic gap(output int g);
    g = 0;
    do begin
      @(negedge clk);
      g++;
    end while (initTrigOut !== 1'b1 && g < 70000);
    chk(adcTrigOut, 1);
  endtask : gap

  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    srst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    fixedTick = 1'b0;
    regAddr = '0;
    regWdata = '0;
    cyc = 0;
    miscompares = 0;
    comparisons = 0;
    void'($urandom(32'h19721e1b));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(`MPT_A_CTRL);
    chk(rdv, 32'h80);
    rd(`MPT_A_MOD);
    chk(rdv, 32'hFFFF);
    // new modulo waits for the full wrap of the reset modulo
    wr(`MPT_A_MOD, 32'h3);
    wr(`MPT_A_CTRL, 32'h280);
    gap(n);
    gap(n);
    chk(n, 4);
    for (int ps = 0; ps < 8; ps++) begin
      wr(`MPT_A_CTRL, 32'h280 | (ps << 2));
      gap(n);
      gap(n);
      chk(n, 4 << ps);
    end
    rd(`MPT_A_STAT);
    chk(rdv[`MPT_S_TOF], 1);
    chk(irq, 1);
    // mid-period modulo write only shows after the next wrap
    wr(`MPT_A_CTRL, 32'h284);
    gap(n);
    wr(`MPT_A_MOD, 32'h7);
    gap(n);
    // rest of the old 8-cycle period, less the cycle the write spends
    chk(n, 7);
    gap(n);
    chk(n, 16);
    wr(`MPT_A_CTRL, 32'h280);
    wr(`MPT_A_TRIG, 32'h5);
    gap(n);
    c0 = 0;
    repeat (16) begin
      @(negedge clk);
      c0 += extTrigOut;
      chk(adcTrigOut, initTrigOut | extTrigOut);
    end
    chk(c0, 2);
    // duty of channel 0 in both polarities
    for (int pol = 0; pol < 2; pol++) begin
      cv = 1 + $urandom % 7;
      wr(`MPT_A_POL, pol);
      wr(8'h40, MD_PWM);
      wr(8'h60, cv);
      gap(n);
      gap(n);
      c0 = 0;
      po = |chOut;
      repeat (8) begin
        @(negedge clk);
        c0 += chOut[0];
        chk(chOrTrigOut, po);
        po = |chOut;
      end
      chk(c0, pol ? 8 - cv : cv);
      chk(chOutEn[0], 1);
    end
    wr(`MPT_A_POL, 32'h0);
    wr(8'h48, MD_CMP);
    gap(n);
    chk(chOutEn[2], 1);
    // compare output toggles once per 8-cycle period
    c0 = chOut[2];
    repeat (8) @(negedge clk);
    chk(chOut[2], !c0);
    // each fault line alone forces every output to its safe level
    for (int i = 0; i < 4; i++) begin
      wr(`MPT_A_DT, 32'h100 << i);
      mpt_pins_model_i.fault[i] <= 1'b1;
      repeat (6) @(negedge clk);
      chk(chOut, 0);
      rd(`MPT_A_STAT);
      chk(rdv[`MPT_S_FLT], 1);
      @(posedge clk);
      mpt_pins_model_i.fault[i] <= 1'b0;
      repeat (4) @(posedge clk);
      wr(`MPT_A_STAT, 32'h2);
      rd(`MPT_A_STAT);
      chk(rdv[`MPT_S_FLT], 0);
    end
    // dead time trims each rising edge of the pair by two cycles
    wr(`MPT_A_DT, 32'h2);
    cv = 3 + $urandom % 3;
    wr(8'h60, cv);
    gap(n);
    gap(n);
    c0 = 0;
    w = 0;
    repeat (8) begin
      @(negedge clk);
      c0 += chOut[0];
      w += chOut[1];
    end
    chk(c0, cv - 2);
    chk(w, 6 - cv);
    // pin state, then a pulse measured by dual-edge capture
    wr(8'h44, 32'h5);
    @(posedge clk);
    mpt_pins_model_i.chIn[1] <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`MPT_A_PINS);
    chk(rdv[1], 1);
    @(posedge clk);
    mpt_pins_model_i.chIn[1] <= 1'b0;
    repeat (4) @(posedge clk);
    w = 2 + $urandom % 5;
    mpt_pins_model_i.chIn[1] <= 1'b1;
    repeat (w) @(posedge clk);
    mpt_pins_model_i.chIn[1] <= 1'b0;
    repeat (6) @(posedge clk);
    rd(8'h64);
    cv = rdv;
    rd(8'h84);
    chk((rdv - cv) & 32'h7, w);
    rd(`MPT_A_CHFL);
    chk(rdv[1], 1);
    // source off holds the count, external source moves it
    wr(`MPT_A_CTRL, 32'h283);
    rd(`MPT_A_CNT);
    c0 = rdv;
    repeat (20) @(posedge clk);
    rd(`MPT_A_CNT);
    chk(rdv, c0);
    wr(`MPT_A_CTRL, 32'h282);
    mpt_pins_model_i.extRun <= 1'b1;
    rd(`MPT_A_CNT);
    c0 = rdv;
    repeat (20) @(posedge clk);
    rd(`MPT_A_CNT);
    // an edge every second cycle: ten between the reads, wrap at 8
    chk(rdv, (c0 + 10) % 8);
    wrap_up();
  end
endmodule : tb_mpt_timer
`default_nettype wire
